// ---- itl_pin_latch.sv ----
`timescale 1ns/1ps
`include "itl_regs.svh"

module itl_latch_unit (
   input  wire logic          clock,
   input  wire logic          rst_b,
   input  wire logic          ce,
   input  wire logic          latch_cnt,
   input  wire logic          latch_sts,
   input  wire logic          reprog,
   input  wire logic          rd,
   input  itl_pkg::itl_cnt_info_s info,
   output logic [7:0]         rd_byte,
   output logic               cnt_held,
   output logic               sts_held
);
   import itl_pkg::*;

   logic [15:0] hold_q;
   logic [7:0]  sts_q;
   logic        cnt_held_q;
   logic        sts_held_q;
   logic        msb_next_q;
   logic [15:0] src;
   logic        last_byte;
   logic        cnt_release;
   logic        sts_release;
   logic [7:0]  sts_now;

   assign sts_now     = {info.out, info.null_count, info.fmt, info.mode, info.bcd};
   assign src         = cnt_held_q ? hold_q : info.count;
   assign last_byte   = (info.fmt != `ITL_FMT_BOTH) || msb_next_q;
   assign sts_release = rd && sts_held_q;
   assign cnt_release = rd && !sts_held_q && cnt_held_q && last_byte;
   assign cnt_held    = cnt_held_q;
   assign sts_held    = sts_held_q;

   // Status wins the first read; then bytes follow the programmed order
   always_comb begin
      if (sts_held_q) begin
         rd_byte = sts_q;
      end else if ((info.fmt == `ITL_FMT_MSB) ||
                   ((info.fmt == `ITL_FMT_BOTH) && msb_next_q)) begin
         rd_byte = src[15:8];
      end else begin
         rd_byte = src[7:0];
      end
   end

   // A new latch in the cycle of the final read is taken, not lost
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         hold_q     <= 16'h0000;
         cnt_held_q <= 1'b0;
      end else if (ce) begin
         if (reprog) begin
            cnt_held_q <= 1'b0;
         end else if (latch_cnt && (!cnt_held_q || cnt_release)) begin
            hold_q     <= info.count;
            cnt_held_q <= 1'b1;
         end else if (cnt_release) begin
            cnt_held_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         sts_q      <= 8'h00;
         sts_held_q <= 1'b0;
      end else if (ce) begin
         if (reprog) begin
            sts_held_q <= 1'b0;
         end else if (latch_sts && (!sts_held_q || sts_release)) begin
            sts_q      <= sts_now;
            sts_held_q <= 1'b1;
         end else if (sts_release) begin
            sts_held_q <= 1'b0;
         end
      end
   end

   // One byte pointer serves latched and live reads alike
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         msb_next_q <= 1'b0;
      end else if (ce) begin
         if (reprog) begin
            msb_next_q <= 1'b0;
         end else if (rd && !sts_held_q && (info.fmt == `ITL_FMT_BOTH)) begin
            msb_next_q <= !msb_next_q;
         end
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);

   a_latch_capture:
      assert property (ce && latch_cnt && !cnt_held_q && !reprog
                       |=> cnt_held_q && hold_q == $past(info.count))
      else $error("count latch did not capture the live count");
   a_second_ignored:
      assert property (ce && latch_cnt && cnt_held_q && !cnt_release && !reprog
                       |=> cnt_held_q && $stable(hold_q))
      else $error("held count was overwritten by a later latch");
   a_read_release:
      assert property (ce && cnt_release && !latch_cnt && !reprog |=> !cnt_held_q)
      else $error("held count not released after full read");
   a_reprog_release:
      assert property (ce && reprog |=> !cnt_held_q && !sts_held_q && !msb_next_q)
      else $error("reprogramming left a latch in place");
   a_status_first:
      assert property (sts_held_q && !cnt_held_q && !latch_sts && !reprog ##0 ce && rd
                       |-> rd_byte == sts_q ##1 !sts_held_q)
      else $error("status byte not returned first");
   a_status_layout:
      assert property (ce && latch_sts && !sts_held_q && !reprog
                       |=> sts_q[7] == $past(info.out) && sts_q[6] == $past(info.null_count)
                           && sts_q[0] == $past(info.bcd) && sts_q[5:4] == $past(info.fmt))
      else $error("status byte fields misplaced");

   c_both_latched: cover property (sts_held_q && cnt_held_q ##1 !sts_held_q && cnt_held_q);

endmodule // itl_latch_unit

module itl_pin_latch (
   input  wire logic                   clock,
   input  wire logic                   rst_b,
   input  wire logic                   ce,
   input  itl_pkg::itl_io_req_s        io_req,
   output logic [7:0]                  io_rdata,
   output logic                        io_rvalid,
   input  itl_pkg::itl_cnt_info_s [2:0] cnt_info,
   output logic [2:0]                  cnt_reprog,
   input  wire logic                   timer_clk_tick,
   input  wire logic                   timer_pin_a_in,
   output logic                        timer_pin_a_out,
   output logic                        timer_pin_a_oe,
   input  wire logic                   timer_pin_b_in,
   output logic                        timer_pin_b_out,
   output logic                        timer_pin_b_oe,
   output logic                        counter0_enable_input,
   output logic                        counter1_enable_input,
   output logic                        counter0_tick_input,
   output logic                        counter1_tick_input
);
   import itl_pkg::*;

   logic [5:0] pinctl_q;
   logic       pa_meta_q;
   logic       pa_s_q;
   logic       pb_meta_q;
   logic       pb_s_q;
   logic       wr_cmd;
   logic       rd_hit;
   logic [1:0] cmd_sel;
   logic [1:0] cmd_fmt;
   logic [2:0] latch_cnt;
   logic [2:0] latch_sts;
   logic [2:0] reprog;
   logic [2:0] cnt_rd;
   logic [2:0] cnt_held;
   logic [2:0] sts_held;
   logic [7:0] unit_byte [3];
   logic [7:0] rd_mux;
   logic [1:0] pa_fn;
   logic [1:0] pb_fn;
   logic       counter0_enable_input_d;
   logic       counter1_enable_input_d;

   assign cmd_sel = io_req.wdata[`ITL_CMD_SEL];
   assign cmd_fmt = io_req.wdata[`ITL_CMD_FMT];
   assign wr_cmd  = ce && io_req.wr && (io_req.addr == `ITL_PORT_CMD);
   assign pa_fn   = pinctl_q[`ITL_PC_PINA];
   assign pb_fn   = pinctl_q[`ITL_PC_PINB];

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_cnt
         localparam logic [1:0] SEL = 2'(gi);
         logic sel_hit;
         logic rb_pick;
         assign sel_hit = wr_cmd && (cmd_sel == SEL);
         // Read-back bit 0 is left unread: it is held zero by software
         assign rb_pick = wr_cmd && (cmd_sel == `ITL_SEL_READBACK)
                          && io_req.wdata[gi + 1];
         assign latch_cnt[gi] = (sel_hit && (cmd_fmt == `ITL_FMT_LATCH))
                                || (rb_pick && !io_req.wdata[`ITL_RB_NOCNT]);
         assign latch_sts[gi] = rb_pick && !io_req.wdata[`ITL_RB_NOSTS];
         assign reprog[gi]    = sel_hit && (cmd_fmt != `ITL_FMT_LATCH);
         assign cnt_rd[gi]    = ce && io_req.rd
                                && (io_req.addr == (`ITL_PORT_READBACK_PICK_COUNTER0 + 16'(gi)));
         itl_latch_unit u_unit (
            .clock     (clock),
            .rst_b     (rst_b),
            .ce        (ce),
            .latch_cnt (latch_cnt[gi]),
            .latch_sts (latch_sts[gi]),
            .reprog    (reprog[gi]),
            .rd        (cnt_rd[gi]),
            .info      (cnt_info[gi]),
            .rd_byte   (unit_byte[gi]),
            .cnt_held  (cnt_held[gi]),
            .sts_held  (sts_held[gi])
         );
      end
   endgenerate

   // Not-loaded flag passes through the status byte as the counter reports it
   always_comb begin
      rd_hit = io_req.rd;
      case (io_req.addr)
         `ITL_PORT_READBACK_PICK_COUNTER0:   rd_mux = unit_byte[0];
         `ITL_PORT_READBACK_PICK_COUNTER1:   rd_mux = unit_byte[1];
         `ITL_PORT_READBACK_PICK_COUNTER2:   rd_mux = unit_byte[2];
         `ITL_PORT_PINCTL: rd_mux = {cnt_info[1].out, cnt_info[0].out, pinctl_q};
         default: begin
            rd_mux = 8'h00;
            rd_hit = 1'b0;
         end
      endcase
   end

   // Answer one cycle after the read strobe; unmapped reads get no answer
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         io_rdata  <= 8'h00;
         io_rvalid <= 1'b0;
      end else if (ce) begin
         io_rvalid <= rd_hit;
         if (rd_hit) begin
            io_rdata <= rd_mux;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         cnt_reprog <= 3'h0;
      end else if (ce) begin
         cnt_reprog <= reprog;
      end
   end

   // Output bits are not stored, so a write cannot touch them
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         pinctl_q <= `ITL_PC_RESET;
      end else if (ce && io_req.wr && (io_req.addr == `ITL_PORT_PINCTL)) begin
         pinctl_q <= io_req.wdata[`ITL_PC_STORED];
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         pa_meta_q <= 1'b0;
         pa_s_q    <= 1'b0;
         pb_meta_q <= 1'b0;
         pb_s_q    <= 1'b0;
      end else if (ce) begin
         pa_meta_q <= timer_pin_a_in;
         pa_s_q    <= pa_meta_q;
         pb_meta_q <= timer_pin_b_in;
         pb_s_q    <= pb_meta_q;
      end
   end

   always_comb begin
      if ((pa_fn == `ITL_PIN_COUNTER0_ENABLE_INPUT) || (pb_fn == `ITL_PIN_COUNTER0_ENABLE_INPUT)) begin
         counter0_enable_input_d = ((pa_fn == `ITL_PIN_COUNTER0_ENABLE_INPUT) && pa_s_q)
                   || ((pb_fn == `ITL_PIN_COUNTER0_ENABLE_INPUT) && pb_s_q);
      end else begin
         counter0_enable_input_d = pinctl_q[`ITL_PC_TG0];
      end
      if ((pa_fn == `ITL_PIN_COUNTER1_ENABLE_INPUT) || (pb_fn == `ITL_PIN_COUNTER1_ENABLE_INPUT)) begin
         counter1_enable_input_d = ((pa_fn == `ITL_PIN_COUNTER1_ENABLE_INPUT) && pa_s_q)
                   || ((pb_fn == `ITL_PIN_COUNTER1_ENABLE_INPUT) && pb_s_q);
      end else begin
         counter1_enable_input_d = pinctl_q[`ITL_PC_TG1];
      end
   end

   // Tick source swaps without glitch filtering; select before counting
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         counter0_enable_input <= 1'b0;
         counter1_enable_input <= 1'b0;
         counter0_tick_input   <= 1'b0;
         counter1_tick_input   <= 1'b0;
         timer_pin_a_out       <= 1'b0;
         timer_pin_a_oe        <= 1'b0;
         timer_pin_b_out       <= 1'b0;
         timer_pin_b_oe        <= 1'b0;
      end else if (ce) begin
         counter0_enable_input <= counter0_enable_input_d;
         counter1_enable_input <= counter1_enable_input_d;
         counter0_tick_input   <= (pb_fn == `ITL_PIN_TICK) ? pb_s_q : timer_clk_tick;
         counter1_tick_input   <= (pa_fn == `ITL_PIN_TICK) ? pa_s_q : timer_clk_tick;
         timer_pin_a_out       <= cnt_info[0].out;
         timer_pin_a_oe        <= (pa_fn == `ITL_PIN_OUT);
         timer_pin_b_out       <= cnt_info[1].out;
         timer_pin_b_oe        <= (pb_fn == `ITL_PIN_OUT);
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);

   a_gate_or:
      assert property (ce && pa_fn == `ITL_PIN_COUNTER0_ENABLE_INPUT && pb_fn == `ITL_PIN_COUNTER0_ENABLE_INPUT
                       |=> counter0_enable_input == ($past(pa_s_q) || $past(pb_s_q)))
      else $error("gate 0 is not the OR of both pins");
   a_soft_gate:
      assert property (ce && pa_fn != `ITL_PIN_COUNTER1_ENABLE_INPUT && pb_fn != `ITL_PIN_COUNTER1_ENABLE_INPUT
                       |=> counter1_enable_input == $past(pinctl_q[`ITL_PC_TG1]))
      else $error("soft gate 1 not applied");
   a_ctl_readback:
      assert property (ce && io_req.rd && io_req.addr == `ITL_PORT_PINCTL
                       |=> io_rvalid && io_rdata[`ITL_PC_COUNTER1_OUTPUT_LEVEL] == $past(cnt_info[1].out)
                           && io_rdata[`ITL_PC_COUNTER0_OUTPUT_LEVEL] == $past(cnt_info[0].out))
      else $error("routing register does not show output levels");
   a_pin_b_out:
      assert property (ce && pb_fn == `ITL_PIN_OUT
                       |=> timer_pin_b_oe && timer_pin_b_out == $past(cnt_info[1].out))
      else $error("pin B not driving counter 1 output");
   a_pin_a_tick:
      assert property (ce && pa_fn == `ITL_PIN_TICK
                       |=> !timer_pin_a_oe && counter1_tick_input == $past(pa_s_q))
      else $error("pin A not feeding counter 1 tick");
   a_rb_same_cycle:
      assert property (wr_cmd && cmd_sel == `ITL_SEL_READBACK && io_req.wdata[3:1] == 3'h7
                       && !io_req.wdata[`ITL_RB_NOCNT] && cnt_held == 3'h0
                       |=> cnt_held == 3'h7)
      else $error("read-back did not latch all picked counters together");

   c_rb_all: cover property (wr_cmd && cmd_sel == `ITL_SEL_READBACK ##1 sts_held == 3'h7);
   c_gate_or: cover property (pa_fn == `ITL_PIN_COUNTER1_ENABLE_INPUT && pb_fn == `ITL_PIN_COUNTER1_ENABLE_INPUT);
   c_latch_read: cover property (cnt_held[0] ##1 !cnt_held[0]);

endmodule // itl_pin_latch

// ---- itl_regs.svh ----
`ifndef ITL_REGS_SVH
`define ITL_REGS_SVH

// Port addresses on the CPU I/O bus
`define ITL_PORT_READBACK_PICK_COUNTER0      16'h0040
`define ITL_PORT_READBACK_PICK_COUNTER1      16'h0041
`define ITL_PORT_READBACK_PICK_COUNTER2      16'h0042
`define ITL_PORT_CMD       16'h0043
`define ITL_PORT_PINCTL    16'h0044

// Command byte fields
`define ITL_CMD_SEL        7:6
`define ITL_CMD_FMT        5:4
`define ITL_RB_NOCNT       5
`define ITL_RB_NOSTS       4
`define ITL_RB_PICK        3:1
`define ITL_SEL_READBACK   2'h3
`define ITL_FMT_LATCH      2'h0
`define ITL_FMT_LSB        2'h1
`define ITL_FMT_MSB        2'h2
`define ITL_FMT_BOTH       2'h3

// Pin routing control register fields
`define ITL_PC_COUNTER1_OUTPUT_LEVEL        7
`define ITL_PC_COUNTER0_OUTPUT_LEVEL        6
`define ITL_PC_TG1         5
`define ITL_PC_TG0         4
`define ITL_PC_PINB        3:2
`define ITL_PC_PINA        1:0
`define ITL_PC_STORED      5:0
`define ITL_PC_RESET       6'h00

// Pin function codes
`define ITL_PIN_COUNTER0_ENABLE_INPUT      2'h0
`define ITL_PIN_COUNTER1_ENABLE_INPUT      2'h1
`define ITL_PIN_OUT        2'h2
`define ITL_PIN_TICK       2'h3

`endif

// ---- itl_pkg.sv ----
package itl_pkg;

   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } itl_io_req_s;

   // Per-counter state presented by the counting logic
   typedef struct packed {
      logic [15:0] count;
      logic        out;
      logic        null_count;
      logic [1:0]  fmt;
      logic [2:0]  mode;
      logic        bcd;
   } itl_cnt_info_s;

endpackage

// ---- itl_far_model.sv ----
`timescale 1ns/1ps

// Counting logic and outside pin drivers seen from the latch block
module itl_far_model (
   input  wire logic                    clock,
   input  itl_pkg::itl_cnt_info_s [2:0] cfg,
   output itl_pkg::itl_cnt_info_s [2:0] cnt_info,
   input  wire logic                    pin_a_out,
   input  wire logic                    pin_a_oe,
   input  wire logic                    pin_b_out,
   input  wire logic                    pin_b_oe,
   input  wire logic                    ext_a,
   input  wire logic                    ext_b,
   output logic                         pin_a_in,
   output logic                         pin_b_in
);
   import itl_pkg::*;

   logic [15:0] cnt_q [3] = '{16'h1234, 16'h8001, 16'hFFFE};

   // Counts never rest, so a capture taken one cycle late is caught
   always @(posedge clock) begin
      for (int k = 0; k < 3; k++) cnt_q[k] <= cnt_q[k] - 16'(3 * k + 1);
   end

   always_comb begin
      for (int k = 0; k < 3; k++) begin
         cnt_info[k]       = cfg[k];
         cnt_info[k].count = cnt_q[k];
      end
   end

   // Outside driver holds the pin whenever the block lets go of it
   assign pin_a_in = pin_a_oe ? pin_a_out : ext_a;
   assign pin_b_in = pin_b_oe ? pin_b_out : ext_b;
endmodule // itl_far_model

// ---- tb.sv ----
`timescale 1ns/1ps

module tb;
   import itl_pkg::*;

   logic                 clock = 1'b0;
   logic                 rst_b = 1'b0;
   logic                 ce = 1'b1;
   logic                 tick = 1'b0;
   logic                 ext_a = 1'b0;
   logic                 ext_b = 1'b0;
   itl_io_req_s          io_req = '0;
   itl_cnt_info_s [2:0]  cfg = '0;
   itl_cnt_info_s [2:0]  cnt_info;
   logic [7:0]           io_rdata;
   logic                 io_rvalid;
   logic [2:0]           cnt_reprog;
   logic                 pa_in, pa_out, pa_oe, pb_in, pb_out, pb_oe;
   logic                 g0, g1, t0, t1;
   int                   fail_count = 0;
   int                   comparisons = 0;
   integer               seed = 32'hdf9d;
   logic [7:0]           exp_q [$];
   string                name_q [$];
   logic [15:0]          cap [3];
   logic [7:0]           wv;

   always #20 clock = ~clock;

   itl_pin_latch u_dut (.clock(clock), .rst_b(rst_b), .ce(ce), .io_req(io_req),
      .io_rdata(io_rdata), .io_rvalid(io_rvalid), .cnt_info(cnt_info),
      .cnt_reprog(cnt_reprog), .timer_clk_tick(tick), .timer_pin_a_in(pa_in),
      .timer_pin_a_out(pa_out), .timer_pin_a_oe(pa_oe), .timer_pin_b_in(pb_in),
      .timer_pin_b_out(pb_out), .timer_pin_b_oe(pb_oe), .counter0_enable_input(g0),
      .counter1_enable_input(g1), .counter0_tick_input(t0), .counter1_tick_input(t1));

   itl_far_model u_far (.clock(clock), .cfg(cfg), .cnt_info(cnt_info),
      .pin_a_out(pa_out), .pin_a_oe(pa_oe), .pin_b_out(pb_out), .pin_b_oe(pb_oe),
      .ext_a(ext_a), .ext_b(ext_b), .pin_a_in(pa_in), .pin_b_in(pb_in));

   task automatic test_done();
      $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value %s: expected %h, seen %h", what, exp, seen);
      end
   endtask

   task automatic io(input logic r, input logic w, input logic [15:0] a, input logic [7:0] d);
      io_req <= '{rd: r, wr: w, addr: a, wdata: d};
      @(negedge clock);
   endtask

   task automatic idle(input int n);
      io_req <= '0;
      repeat (n) @(negedge clock);
   endtask

   task automatic rd_exp(input logic [15:0] a, input logic [7:0] e, input string nm);
      exp_q.push_back(e);
      name_q.push_back(nm);
      io(1'b1, 1'b0, a, 8'h00);
   endtask

   // Bytes leave in the counter's own order; live values are taken per byte
   task automatic rd_count(input int i, input bit live);
      logic [15:0] v;
      v = live ? u_far.cnt_q[i] : cap[i];
      if (cfg[i].fmt != 2'h2) rd_exp(16'h0040 + 16'(i), v[7:0], "count low");
      v = live ? u_far.cnt_q[i] : cap[i];
      if (cfg[i].fmt[1]) rd_exp(16'h0040 + 16'(i), v[15:8], "count high");
   endtask

   function automatic logic [7:0] sts(input int i);
      return {cfg[i].out, cfg[i].null_count, cfg[i].fmt, cfg[i].mode, cfg[i].bcd};
   endfunction

   task automatic pin_case(input logic [7:0] w);
      logic [1:0] pa, pb, on0, on1;
      logic       ea, eb, tk, o0, o1, va, vb;
      pa = w[1:0];
      pb = w[3:2];
      {ea, eb, tk, o0, o1} = 5'($random(seed));
      ext_a <= ea;
      ext_b <= eb;
      tick <= tk;
      cfg[0].out <= o0;
      cfg[1].out <= o1;
      io(1'b0, 1'b1, 16'h0044, w);
      idle(5);
      va = (pa == 2'h2) ? o0 : ea;
      vb = (pb == 2'h2) ? o1 : eb;
      on0 = {pb == 2'h0, pa == 2'h0};
      on1 = {pb == 2'h1, pa == 2'h1};
      check(g0, (on0 != 2'h0) ? |(on0 & {vb, va}) : w[4], "gate 0");
      check(g1, (on1 != 2'h0) ? |(on1 & {vb, va}) : w[5], "gate 1");
      check(t0, (pb == 2'h3) ? vb : tk, "tick 0");
      check(t1, (pa == 2'h3) ? va : tk, "tick 1");
      check({pa_oe, pb_oe}, {pa == 2'h2, pb == 2'h2}, "pin enables");
      check({pa_out & pa_oe, pb_out & pb_oe}, {o0 & pa == 2'h2, o1 & pb == 2'h2}, "pin drive");
      rd_exp(16'h0044, {o1, o0, w[5:0]}, "pin control");
   endtask

   // Oldest expectation is matched against each answer
   always @(negedge clock) begin
      if (io_rvalid === 1'b1) begin
         if (exp_q.size() == 0) check(16'h0001, 16'h0000, "unexpected answer");
         else check(io_rdata, exp_q.pop_front(), name_q.pop_front());
      end
   end

   initial begin
      repeat (5000) @(posedge clock);
      fail_count++;
      test_done();
   end

   initial begin
      repeat (10) @(negedge clock);
      rst_b <= 1'b1;
      for (int k = 0; k < 3; k++) begin
         cfg[k].mode <= 3'($random(seed));
         cfg[k].bcd <= 1'($random(seed));
         cfg[k].null_count <= 1'($random(seed));
         cfg[k].out <= 1'(k);
      end
      cfg[0].fmt <= 2'h1;
      cfg[1].fmt <= 2'h3;
      cfg[2].fmt <= 2'h2;
      @(negedge clock);
      rd_exp(16'h0044, {cfg[1].out, cfg[0].out, 6'h00}, "pin control reset");
      for (int i = 0; i < 3; i++) begin
         cap[i] = u_far.cnt_q[i];
         io(1'b0, 1'b1, 16'h0043, {2'(i), 2'b00, 4'($random(seed))});
         check(cnt_reprog, 3'b000, "no reprogram on latch");
         io(1'b0, 1'b1, 16'h0043, {2'(i), 2'b00, 4'h0});
         io(1'b0, 1'b1, 16'h0043, 8'hD0 | (8'h02 << i));
         idle(3);
         rd_count(i, 1'b0);
         rd_count(i, 1'b1);
      end
      for (int k = 0; k < 3; k++) cap[k] = u_far.cnt_q[k];
      io(1'b0, 1'b1, 16'h0043, 8'hCE);
      idle(2);
      for (int i = 0; i < 3; i++) begin
         rd_exp(16'h0040 + 16'(i), sts(i), "status");
         rd_count(i, 1'b0);
         rd_count(i, 1'b1);
      end
      io(1'b0, 1'b1, 16'h0043, 8'hE8);
      rd_exp(16'h0042, sts(2), "status only");
      rd_count(2, 1'b1);
      io(1'b0, 1'b1, 16'h0043, 8'h80);
      cfg[2].fmt <= 2'h3;
      io(1'b0, 1'b1, 16'h0043, 8'hB4);
      check(cnt_reprog, 3'b100, "reprogram pulse");
      rd_count(2, 1'b1);
      // Let the last answer pulse fall first: a low clock enable would hold it
      idle(1);
      ce <= 1'b0;
      io(1'b1, 1'b0, 16'h0044, 8'h00);
      ce <= 1'b1;
      io(1'b1, 1'b0, 16'h0045, 8'h00);
      io(1'b1, 1'b0, 16'h0043, 8'h00);
      for (int c = 0; c < 32; c++) begin
         wv = 8'($random(seed));
         wv[3:0] = 4'(c);
         pin_case(wv);
      end
      // Reset in mid-run must clear the routing bits written by the loop
      idle(2);
      rst_b <= 1'b0;
      idle(2);
      rst_b <= 1'b1;
      @(negedge clock);
      rd_exp(16'h0044, {cfg[1].out, cfg[0].out, 6'h00}, "pin control after reset");
      idle(3);
      check(16'(exp_q.size()), 16'h0000, "pending reads");
      test_done();
   end
endmodule // tb
